// *** logic/rtes_params.svh ***
// Constants of the event, status and mask logic of the real-time clock
`ifndef RTES_PARAMS_SVH
`define RTES_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define RTES_ADDR_CONTROL       32'h0FFFFEB0
`define RTES_ADDR_DATE_ALARM    32'h0FFFFEC4
`define RTES_ADDR_EVENT_STATUS  32'h0FFFFEC8
`define RTES_ADDR_STATUS_CLEAR  32'h0FFFFECC
`define RTES_ADDR_IRQ_SET       32'h0FFFFED0
`define RTES_ADDR_IRQ_CLEAR     32'h0FFFFED4
`define RTES_ADDR_IRQ_STATE     32'h0FFFFED8
`define RTES_ADDR_VALIDITY      32'h0FFFFEDC

// ****************************************************************
// Field positions
// ****************************************************************
`define RTES_BIT_GRANT          0
`define RTES_BIT_MATCH          1
`define RTES_BIT_ONE_HZ         2
`define RTES_BIT_HMS            3
`define RTES_BIT_DATE           4
`define RTES_BIT_HMS_INVALID    0
`define RTES_BIT_DATE_INVALID   1
`define RTES_BIT_HMS_M_INVALID  2
`define RTES_BIT_DATE_M_INVALID 3
`define RTES_CTL_HMS_REQ        0
`define RTES_CTL_DATE_REQ       1
`define RTES_CTL_HMS_SEL_LO     8
`define RTES_CTL_DATE_SEL_LO    16
`define RTES_ALM_DATE_LO        24
`define RTES_ALM_DATE_ON        31

// ****************************************************************
// Choice encodings and reset values
// ****************************************************************
`define RTES_HMS_MINUTE         2'h0
`define RTES_HMS_HOUR           2'h1
`define RTES_HMS_MIDNIGHT       2'h2
`define RTES_HMS_NOON           2'h3
`define RTES_DATE_WEEK          2'h0
`define RTES_DATE_MONTH         2'h1
`define RTES_DATE_YEAR          2'h2
`define RTES_RST_FLAGS          5'h00
`define RTES_RST_VALID          4'h0
`define RTES_RST_CONTROL        6'h00
`define RTES_RST_DATE_ALARM     7'h01
`define RTES_DATE_MAX           6'h31

`endif

// *** logic/rtes_pkg.sv ***
// Types shared by the event, status and mask logic
package rtes_pkg;

  typedef logic [4:0] rtes_flags_t;
  typedef logic [3:0] rtes_valid_t;
  typedef logic [1:0] rtes_choice_t;

  // Single-cycle pulses from the time and calendar counters
  typedef struct packed {
    logic second;
    logic minute;
    logic hour;
    logic midnight;
    logic noon;
    logic week;
    logic month;
    logic year;
  } rtes_ticks_s;

  // Control fields driving the counters and the event select
  typedef struct packed {
    rtes_choice_t date_choice;
    rtes_choice_t hms_choice;
    logic         date_update_req;
    logic         hms_update_req;
  } rtes_control_s;

endpackage

// *** logic/rtes_sticky_bits.sv ***
// Row of sticky flags with per-bit set and clear, set taking priority
`timescale 1ns/1ps
`default_nettype none

module rtes_sticky_bits #(
  parameter int          WIDTH     = 5,
  parameter logic [31:0] RESET_VAL = 32'h00000000
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Per-bit controls
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clear_i,
  // Flag state
  output logic      [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Set wins so an event in the clearing cycle is not lost
  always_comb
  begin
    flags_next = (flags_reg & ~clear_i) | set_i;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      flags_reg <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule

`default_nettype wire

// *** logic/rtes_status.sv ***
// Event flags, interrupt masks, validity bits and APB slave of the clock
`timescale 1ns/1ps
`default_nettype none
`include "rtes_params.svh"

module rtes_status (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [31:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Counter events
  input  wire rtes_pkg::rtes_ticks_s ticks_i,
  input  wire logic                  update_grant_i,
  // Alarm comparison inputs
  input  wire logic [5:0]            date_bcd_i,
  input  wire logic                  other_match_i,
  input  wire logic                  other_match_on_i,
  // Validity detection from the other registers
  input  wire logic [2:0]            invalid_seen_i,
  input  wire logic [2:0]            reprogram_i,
  // Counter control
  output rtes_pkg::rtes_control_s    control_o,
  // Interrupt
  output logic                       irq_o
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic access;
  logic setup;
  logic wr_access;
  logic rd_access;
  logic hit_control;
  logic hit_alarm;
  logic hit_status;
  logic hit_clear;
  logic hit_set;
  logic hit_unset;
  logic hit_state;
  logic hit_valid;
  logic mapped;

  assign setup       = psel_i & ~penable_i;
  assign access      = psel_i & penable_i;
  assign wr_access   = access & pwrite_i;
  assign rd_access   = access & ~pwrite_i;
  assign hit_control = (paddr_i == `RTES_ADDR_CONTROL);
  assign hit_alarm   = (paddr_i == `RTES_ADDR_DATE_ALARM);
  assign hit_status  = (paddr_i == `RTES_ADDR_EVENT_STATUS);
  assign hit_clear   = (paddr_i == `RTES_ADDR_STATUS_CLEAR);
  assign hit_set     = (paddr_i == `RTES_ADDR_IRQ_SET);
  assign hit_unset   = (paddr_i == `RTES_ADDR_IRQ_CLEAR);
  assign hit_state   = (paddr_i == `RTES_ADDR_IRQ_STATE);
  assign hit_valid   = (paddr_i == `RTES_ADDR_VALIDITY);
  assign mapped      = hit_control | hit_alarm | hit_status | hit_clear
                     | hit_set | hit_unset | hit_state | hit_valid;

  // Zero wait states; error only for an unmapped address
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;

  // ****************************************************************
  // Control register
  // ****************************************************************
  rtes_pkg::rtes_control_s control_reg;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      control_reg <= `RTES_RST_CONTROL;
    end
    else if (wr_access && hit_control)
    begin
      control_reg.hms_update_req  <= pwdata_i[`RTES_CTL_HMS_REQ];
      control_reg.date_update_req <= pwdata_i[`RTES_CTL_DATE_REQ];
      control_reg.hms_choice      <= pwdata_i[`RTES_CTL_HMS_SEL_LO +: 2];
      control_reg.date_choice     <= pwdata_i[`RTES_CTL_DATE_SEL_LO +: 2];
    end
  end

  assign control_o = control_reg;

  // ****************************************************************
  // Date alarm register
  // ****************************************************************
  logic [5:0] alarm_date_reg;
  logic       dom_match_on_reg;
  logic       alarm_write;
  logic [5:0] alarm_date_wr;
  logic       alarm_date_bad;
  // Reset image: date field 01, date match off
  localparam logic [6:0] ALARM_RESET = `RTES_RST_DATE_ALARM;

  assign alarm_write   = wr_access & hit_alarm;
  assign alarm_date_wr = pwdata_i[`RTES_ALM_DATE_LO +: 6];

  // Legal BCD day of month is 01 to 31
  assign alarm_date_bad = (alarm_date_wr[3:0] > 4'h9)
                        | (alarm_date_wr == 6'h00)
                        | (alarm_date_wr > `RTES_DATE_MAX);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      alarm_date_reg   <= ALARM_RESET[5:0];
      dom_match_on_reg <= ALARM_RESET[6];
    end
    else if (alarm_write)
    begin
      alarm_date_reg   <= alarm_date_wr;
      dom_match_on_reg <= pwdata_i[`RTES_ALM_DATE_ON];
    end
  end

  // ****************************************************************
  // Alarm match
  // ****************************************************************
  logic date_ok;
  logic any_match_on;
  logic alarm_event;

  // Disabled date field never blocks a match from the other fields
  assign date_ok      = ~dom_match_on_reg | (date_bcd_i == alarm_date_reg);
  assign any_match_on = dom_match_on_reg | other_match_on_i;
  // Checked once a second so one match gives one event
  assign alarm_event  = ticks_i.second & any_match_on & other_match_i
                      & date_ok;

  // ****************************************************************
  // Event selection
  // ****************************************************************
  logic hms_event;
  logic date_event;

  always_comb
  begin
    case (control_reg.hms_choice)
      `RTES_HMS_MINUTE:   hms_event = ticks_i.minute;
      `RTES_HMS_HOUR:     hms_event = ticks_i.hour;
      `RTES_HMS_MIDNIGHT: hms_event = ticks_i.midnight;
      `RTES_HMS_NOON:     hms_event = ticks_i.noon;
      default:            hms_event = 1'b0;
    endcase
  end

  // Encoding 3 selects nothing, so no calendar event is ever flagged
  always_comb
  begin
    case (control_reg.date_choice)
      `RTES_DATE_WEEK:  date_event = ticks_i.week;
      `RTES_DATE_MONTH: date_event = ticks_i.month;
      `RTES_DATE_YEAR:  date_event = ticks_i.year;
      default:          date_event = 1'b0;
    endcase
  end

  // ****************************************************************
  // Event status flags
  // ****************************************************************
  rtes_pkg::rtes_flags_t flag_set;
  rtes_pkg::rtes_flags_t flag_clear;
  rtes_pkg::rtes_flags_t flag_read_clear;
  rtes_pkg::rtes_flags_t status_flags;
  rtes_pkg::rtes_flags_t seen_reg;

  always_comb
  begin
    flag_set                      = '0;
    flag_set[`RTES_BIT_GRANT]     = update_grant_i;
    flag_set[`RTES_BIT_MATCH]     = alarm_event;
    flag_set[`RTES_BIT_ONE_HZ]    = ticks_i.second;
    flag_set[`RTES_BIT_HMS]       = hms_event;
    flag_set[`RTES_BIT_DATE]      = date_event;
  end

  // A status read clears the event bits it returned, but not the grant
  always_comb
  begin
    flag_read_clear                  = '0;
    if (rd_access && hit_status)
    begin
      flag_read_clear                = seen_reg;
      flag_read_clear[`RTES_BIT_GRANT] = 1'b0;
    end
  end

  // Only the bits the read returned are cleared, so an event landing
  // between the setup and access edges waits for the next read
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      seen_reg <= `RTES_RST_FLAGS;
    end
    else if (setup && !pwrite_i && hit_status)
    begin
      seen_reg <= status_flags;
    end
  end

  always_comb
  begin
    flag_clear = flag_read_clear;
    if (wr_access && hit_clear)
    begin
      flag_clear = flag_read_clear | pwdata_i[4:0];
    end
  end

  rtes_sticky_bits #(
    .WIDTH     (5),
    .RESET_VAL ({27'h0, `RTES_RST_FLAGS})
  ) u_status_flags (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (flag_set),
    .clear_i   (flag_clear),
    .flags_o   (status_flags)
  );

  // ****************************************************************
  // Interrupt mask
  // ****************************************************************
  rtes_pkg::rtes_flags_t mask_reg;
  rtes_pkg::rtes_flags_t mask_next;

  always_comb
  begin
    mask_next = mask_reg;
    if (wr_access && hit_set)
    begin
      mask_next = mask_reg | pwdata_i[4:0];
    end
    else if (wr_access && hit_unset)
    begin
      mask_next = mask_reg & ~pwdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mask_reg <= `RTES_RST_FLAGS;
    end
    else
    begin
      mask_reg <= mask_next;
    end
  end

  // Level output straight from the flag and mask flip-flops
  assign irq_o = |(status_flags & mask_reg);

  // ****************************************************************
  // Validity bits
  // ****************************************************************
  rtes_pkg::rtes_valid_t valid_set;
  rtes_pkg::rtes_valid_t valid_clear;
  rtes_pkg::rtes_valid_t valid_flags;

  always_comb
  begin
    valid_set                            = '0;
    valid_set[2:0]                       = invalid_seen_i;
    valid_set[`RTES_BIT_DATE_M_INVALID]  = alarm_write & alarm_date_bad;
  end

  // Reprogramming clears; a bad value written again sets it back at once
  always_comb
  begin
    valid_clear                           = '0;
    valid_clear[2:0]                      = reprogram_i;
    valid_clear[`RTES_BIT_DATE_M_INVALID] = alarm_write;
  end

  rtes_sticky_bits #(
    .WIDTH     (4),
    .RESET_VAL ({28'h0000000, `RTES_RST_VALID})
  ) u_valid_flags (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .set_i     (valid_set),
    .clear_i   (valid_clear),
    .flags_o   (valid_flags)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = 32'h00000000;
    if (hit_control)
    begin
      rdata_next[`RTES_CTL_HMS_REQ]            = control_reg.hms_update_req;
      rdata_next[`RTES_CTL_DATE_REQ]           = control_reg.date_update_req;
      rdata_next[`RTES_CTL_HMS_SEL_LO +: 2]    = control_reg.hms_choice;
      rdata_next[`RTES_CTL_DATE_SEL_LO +: 2]   = control_reg.date_choice;
    end
    else if (hit_alarm)
    begin
      rdata_next[`RTES_ALM_DATE_LO +: 6]       = alarm_date_reg;
      rdata_next[`RTES_ALM_DATE_ON]            = dom_match_on_reg;
    end
    else if (hit_status)
    begin
      rdata_next[4:0]                          = status_flags;
    end
    else if (hit_state)
    begin
      rdata_next[4:0]                          = mask_reg;
    end
    else if (hit_valid)
    begin
      rdata_next[3:0]                          = valid_flags;
    end
  end

  // Captured in the setup cycle so read data comes from a flip-flop
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_o <= 32'h00000000;
    end
    else if (setup && !pwrite_i)
    begin
      prdata_o <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// *** bench/rtes_status_checker.sv ***
// Concurrent checks on the ports of the event and mask block
`timescale 1ns/1ps
`default_nettype none
`include "rtes_params.svh"

module rtes_status_checker (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    reset_i,
  // APB slave
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [31:0]             paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic [31:0]             prdata_o,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  // Events and control
  input wire rtes_pkg::rtes_ticks_s   ticks_i,
  input wire logic                    update_grant_i,
  input wire rtes_pkg::rtes_control_s control_o,
  input wire logic                    irq_o
);
  logic       acc;
  logic       wr;
  logic       off2;
  logic       off0;
  logic [4:0] mask_reg;
  logic       cause;

  assign acc = psel_i && penable_i;
  assign cause = (ticks_i != 8'h00) || update_grant_i || wr;
  assign wr = acc && pwrite_i;
  assign off2 = wr && paddr_i == `RTES_ADDR_IRQ_CLEAR && pwdata_i[2];
  assign off0 = wr && paddr_i == `RTES_ADDR_IRQ_CLEAR && pwdata_i[0];

  // Shadow of the mask, kept from the bus alone
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      mask_reg <= 5'h00;
    else if (wr && paddr_i == `RTES_ADDR_IRQ_SET)
      mask_reg <= mask_reg | pwdata_i[4:0];
    else if (wr && paddr_i == `RTES_ADDR_IRQ_CLEAR)
      mask_reg <= mask_reg & ~pwdata_i[4:0];

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ready_always_a: assert property (pready_o)
    else $error("pready low");
  err_phase_a: assert property (pslverr_o |-> acc)
    else $error("pslverr outside access");
  mask_read_a: assert property (
    acc && !pwrite_i && paddr_i == `RTES_ADDR_IRQ_STATE |-> prdata_o == {27'h0, mask_reg})
    else $error("mask readback wrong");
  irq_masked_a: assert property (mask_reg == 5'h00 |-> !irq_o)
    else $error("irq with all masked");
  sec_irq_a: assert property (ticks_i.second && mask_reg[2] && !off2 |=> irq_o)
    else $error("second event gave no irq");
  grant_irq_a: assert property (update_grant_i && mask_reg[0] && !off0 |=> irq_o)
    else $error("grant gave no irq");
  irq_cause_a: assert property (
    $rose(irq_o) |-> $past(cause))
    else $error("irq rose without cause");
  irq_hold_a: assert property (
    irq_o && !wr && !(acc && paddr_i == `RTES_ADDR_EVENT_STATUS) |=> irq_o)
    else $error("irq dropped without clear");
  choice_write_a: assert property (
    wr && paddr_i == `RTES_ADDR_CONTROL |=> control_o.hms_choice == $past(pwdata_i[9:8])
      && control_o.date_choice == $past(pwdata_i[17:16]))
    else $error("event choice not stored");
endmodule

bind rtes_status rtes_status_checker rtes_status_checker_i (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ticks_i(ticks_i),
  .update_grant_i(update_grant_i), .control_o(control_o), .irq_o(irq_o)
);

`default_nettype wire

// *** bench/test_rtes_status.sv ***
// Self-checking bench for the event, status and mask block
`timescale 1ns/1ps
`default_nettype none
`include "rtes_params.svh"

module test_rtes_status;
  logic                    clk_i, reset_i, psel_i, penable_i, pwrite_i, update_grant_i;
  logic                    other_match_i, other_match_on_i, pready_o, pslverr_o, irq_o, err;
  logic [31:0]             paddr_i, pwdata_i, prdata_o, rd;
  logic [5:0]              date_bcd_i;
  logic [2:0]              invalid_seen_i, reprogram_i;
  logic [4:0]              m_flags, m_mask;
  rtes_pkg::rtes_ticks_s   ticks_i;
  rtes_pkg::rtes_control_s control_o;
  int                      n_fail, checks, seed, i, j;

  rtes_status rtes_status_i (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ticks_i(ticks_i),
    .update_grant_i(update_grant_i), .date_bcd_i(date_bcd_i),
    .other_match_i(other_match_i), .other_match_on_i(other_match_on_i),
    .invalid_seen_i(invalid_seen_i), .reprogram_i(reprogram_i),
    .control_o(control_o), .irq_o(irq_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq;
    cmp({31'h0, irq_o}, {31'h0, |(m_flags & m_mask)});
  endtask

  // Held until pready is seen high; answer taken at that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 50);
    if (k >= 50)
      n_fail++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == `RTES_ADDR_STATUS_CLEAR)
      m_flags = m_flags & ~d[4:0];
    if (a == `RTES_ADDR_IRQ_SET)
      m_mask = m_mask | d[4:0];
    if (a == `RTES_ADDR_IRQ_CLEAR)
      m_mask = m_mask & ~d[4:0];
    chk_irq;
  endtask

  task automatic rdx(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, err}, {31'h0, a[7:0] == 8'hE0});
  endtask

  // Reading status clears every event flag except the grant
  task automatic rds;
    rdx(`RTES_ADDR_EVENT_STATUS, {27'h0, m_flags});
    m_flags = m_flags & 5'h01;
  endtask

  task automatic pulse(input logic [7:0] t, input logic g);
    ticks_i <= t;
    update_grant_i <= g;
    @(posedge clk_i);
    ticks_i <= 8'h00;
    update_grant_i <= 1'b0;
    @(posedge clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude;
  end

  initial
  begin
    {psel_i, penable_i, pwrite_i, update_grant_i, other_match_i, other_match_on_i} = 6'h00;
    {paddr_i, pwdata_i, ticks_i, invalid_seen_i, reprogram_i} = 78'h0;
    date_bcd_i = 6'h15;
    reset_i = 1'b1;
    seed = 32'h6806;
    m_flags = 5'h00;
    m_mask = 5'h00;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rds;
    rdx(`RTES_ADDR_IRQ_STATE, 32'h0);
    rdx(`RTES_ADDR_VALIDITY, 32'h0);
    rdx(32'h0FFFFEE0, 32'h0);
    repeat (6)
    begin
      wr(`RTES_ADDR_IRQ_SET, $random(seed));
      rdx(`RTES_ADDR_IRQ_STATE, {27'h0, m_mask});
      wr(`RTES_ADDR_IRQ_CLEAR, $random(seed));
      rdx(`RTES_ADDR_IRQ_STATE, {27'h0, m_mask});
    end
    wr(`RTES_ADDR_IRQ_SET, 32'h0000001F);
    // Each choice against each tick: only the chosen one may flag
    for (i = 0; i < 4; i++)
    begin
      wr(`RTES_ADDR_CONTROL, {14'h0, i[1:0], 6'h0, i[1:0], 6'h0, i[1:0]});
      cmp({26'h0, control_o}, {26'h0, i[1:0], i[1:0], i[1:0]});
      for (j = 0; j < 4; j++)
      begin
        pulse(8'h40 >> j, 1'b0);
        m_flags[3] = m_flags[3] | (i == j);
        chk_irq;
        pulse((j < 3) ? 8'h04 >> j : 8'h80, 1'b0);
        m_flags[4] = m_flags[4] | (i == j && j < 3);
        m_flags[2] = m_flags[2] | (j == 3);
        chk_irq;
        rds;
      end
    end
    pulse(8'h00, 1'b1);
    m_flags[0] = 1'b1;
    chk_irq;
    rds;
    rds;
    wr(`RTES_ADDR_EVENT_STATUS, 32'h0000001F);
    repeat (5)
    begin
      pulse(8'h88, 1'b1);
      m_flags = m_flags | 5'h0D;
      wr(`RTES_ADDR_STATUS_CLEAR, $random(seed));
      rds;
    end
    // A second event between a read's setup and access edges survives it
    fork
      rds;
      pulse(8'h80, 1'b0);
    join
    m_flags[2] = 1'b1;
    rds;
    // Date field: matched, mismatched, then left out of the match
    other_match_i <= 1'b1;
    wr(`RTES_ADDR_DATE_ALARM, 32'h95000000);
    pulse(8'h80, 1'b0);
    m_flags[2:1] = 2'b11;
    rds;
    wr(`RTES_ADDR_DATE_ALARM, 32'h96000000);
    pulse(8'h80, 1'b0);
    m_flags[2] = 1'b1;
    rds;
    other_match_on_i <= 1'b1;
    wr(`RTES_ADDR_DATE_ALARM, 32'h16000000);
    pulse(8'h80, 1'b0);
    m_flags[2:1] = 2'b11;
    rds;
    other_match_i <= 1'b0;
    pulse(8'h80, 1'b0);
    m_flags[2] = 1'b1;
    rds;
    invalid_seen_i <= 3'h7;
    @(posedge clk_i);
    invalid_seen_i <= 3'h0;
    wr(`RTES_ADDR_DATE_ALARM, 32'hBA000000);
    rdx(`RTES_ADDR_VALIDITY, 32'h0000000F);
    reprogram_i <= 3'h5;
    @(posedge clk_i);
    reprogram_i <= 3'h0;
    wr(`RTES_ADDR_DATE_ALARM, 32'h01000000);
    rdx(`RTES_ADDR_VALIDITY, 32'h00000002);
    conclude;
  end
endmodule

`default_nettype wire
